// ==== logic/rslp_regs.svh ====
// Named constants for the reset strap and low power sequencer.
`ifndef RSLP_REGS_SVH
`define RSLP_REGS_SVH
`define RSLP_NUM_CORES         2
`define RSLP_SG_ENTRY_CLKS     20
`define RSLP_SG_CNT_W          5
`define RSLP_SG_CNT_ONE        5'h01
`define RSLP_SG_CNT_ZERO       5'h00
`define RSLP_EVT_W             4
`define RSLP_EVT_SMI           0
`define RSLP_EVT_INIT          1
`define RSLP_EVT_NMI           2
`define RSLP_EVT_MASKABLE_IRQ          3
`define RSLP_EVT_NONE          4'h0
`define RSLP_STRAP_W           3
`define RSLP_STRAP_TRISTATE    0
`define RSLP_STRAP_SELF_TEST   1
`define RSLP_STRAP_ARB_ID      2
`define RSLP_STRAP_RESET_VAL   3'h0
`endif

// ==== logic/rslp_pkg.sv ====
// Types shared by the reset strap and low power sequencer.
package rslp_pkg;
  typedef enum logic [2:0] {
    RSLP_NORMAL    = 3'h0,
    RSLP_HALT      = 3'h1,
    RSLP_HALT_SNP  = 3'h2,
    RSLP_SGA_WAIT  = 3'h3,
    RSLP_SG_DELAY  = 3'h4,
    RSLP_STOP      = 3'h5,
    RSLP_STOP_SNP  = 3'h6
  } rslp_state_t;
endpackage

// ==== logic/rslp_strap.sv ====
// Strap capture on reset release.
`timescale 1ns/1ps
`include "rslp_regs.svh"
module rslp_strap (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      sys_mgmt_irq_n,
  input  wire logic                      self_test_strap_n,
  input  wire logic                      bus_request_zero_n,
  output logic [`RSLP_STRAP_W-1:0]       strap_cfg
);
  typedef struct packed {
    logic [`RSLP_STRAP_W-1:0] live;
    logic [`RSLP_STRAP_W-1:0] cfg;
    logic                     in_rst;
  } rslp_strap_state_t;
  rslp_strap_state_t st_q;
  rslp_strap_state_t st_d;

  // Track straps during reset and freeze them on the first edge after release.
  always_comb begin
    st_d        = st_q;
    st_d.in_rst = ~rst_b;
    st_d.live   = {~bus_request_zero_n, ~self_test_strap_n, ~sys_mgmt_irq_n};
    if (st_q.in_rst && rst_b) begin
      st_d.cfg = st_q.live;
    end
  end

  // Configuration only changes at a reset release, warm or cold alike.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_q.in_rst <= 1'b1;
      st_q.live   <= st_d.live;
      st_q.cfg    <= st_q.cfg;
    end else begin
      st_q <= st_d;
    end
  end

  assign strap_cfg = st_q.cfg;

  // Once the release edge has passed, the captured value may not move until the next reset.
  a_cfg_stable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !st_q.in_rst |=> $stable(strap_cfg))
    else $error("Strap configuration changed outside reset release.");
endmodule

// ==== logic/rslp_events.sv ====
// One-deep pending flags for low power wake events.
`timescale 1ns/1ps
`include "rslp_regs.svh"
module rslp_events (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic [`RSLP_EVT_W-1:0]    evt_in,
  input  wire logic [`RSLP_EVT_W-1:0]    evt_take,
  output logic [`RSLP_EVT_W-1:0]         evt_pend
);
  typedef struct packed {
    logic [`RSLP_EVT_W-1:0] pend;
  } rslp_evt_state_t;
  rslp_evt_state_t st_q;
  rslp_evt_state_t st_d;

  // One flag per event type; a new event in the taking cycle wins.
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < `RSLP_EVT_W; i++) begin
      if (evt_in[i]) begin
        st_d.pend[i] = 1'b1;
      end else if (evt_take[i]) begin
        st_d.pend[i] = 1'b0;
      end
    end
  end

  // Pending events are cleared by reset.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_q.pend <= `RSLP_EVT_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign evt_pend = st_q.pend;
endmodule

// ==== logic/rslp_seq.sv ====
// Low power state sequencer with reset strap capture.
`timescale 1ns/1ps
`include "rslp_regs.svh"
module rslp_seq (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  input  wire logic                          sys_mgmt_irq_n,
  input  wire logic                          self_test_strap_n,
  input  wire logic                          bus_request_zero_n,
  input  wire logic                          init_n,
  input  wire logic [1:0]                    local_irq_lines,
  input  wire logic                          clock_stop_request_n,
  input  wire logic [`RSLP_NUM_CORES-1:0]    core_halted,
  input  wire logic                          smm_return,
  input  wire logic                          smm_return_to_halt,
  input  wire logic                          snoop_seen,
  input  wire logic                          snoop_done,
  input  wire logic                          sga_response,
  output logic                               sga_issue,
  output logic [2:0]                         power_state,
  output logic                               in_stop_grant,
  output logic                               output_tristate,
  output logic                               built_in_self_test,
  output logic                               arb_id_sym,
  output logic [`RSLP_EVT_W-1:0]             service_evt,
  output logic                               init_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  // Local state.
  typedef struct packed {
    rslp_pkg::rslp_state_t     fsm;
    logic [`RSLP_SG_CNT_W-1:0] cnt;
    logic                      from_halt;
    logic                      sga;
    logic                      init;
    logic                      rst_seen;
    logic [`RSLP_EVT_W-1:0]    svc;
  } rslp_seq_state_t;
  rslp_seq_state_t st_q;
  rslp_seq_state_t st_d;

  logic [`RSLP_STRAP_W-1:0] strap_cfg;
  logic [`RSLP_EVT_W-1:0]   evt_in;
  logic [`RSLP_EVT_W-1:0]   evt_pend;
  logic [`RSLP_EVT_W-1:0]   evt_take;
  logic                     stop_req;
  logic                     all_halted;
  logic                     wake;

  ////////////////////////////////////////////////////////////////////////////
  // Straps and wake events.
  rslp_strap u_strap (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .sys_mgmt_irq_n     (sys_mgmt_irq_n),
    .self_test_strap_n  (self_test_strap_n),
    .bus_request_zero_n (bus_request_zero_n),
    .strap_cfg          (strap_cfg)
  );

  // Maskable and non-maskable local lines are the two bits of local_irq_lines.
  assign evt_in   = {local_irq_lines[0], local_irq_lines[1], ~init_n, ~sys_mgmt_irq_n};
  assign evt_take = st_d.svc;

  rslp_events u_events (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .evt_in   (evt_in),
    .evt_take (evt_take),
    .evt_pend (evt_pend)
  );

  // Decoded conditions.
  assign stop_req   = ~clock_stop_request_n;
  assign all_halted = &core_halted;
  assign wake       = |evt_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Next state logic.
  always_comb begin
    st_d      = st_q;
    st_d.sga  = 1'b0;
    st_d.init = 1'b0;
    st_d.svc  = `RSLP_EVT_NONE;
    case (st_q.fsm)
      rslp_pkg::RSLP_NORMAL: begin
        st_d.svc = evt_pend;
        if (smm_return && smm_return_to_halt) begin
          st_d.fsm = rslp_pkg::RSLP_HALT;
        end else if (stop_req) begin
          st_d.from_halt = 1'b0;
          st_d.sga       = 1'b1;
          st_d.fsm       = rslp_pkg::RSLP_SGA_WAIT;
        end else if (all_halted && !wake) begin
          st_d.fsm = rslp_pkg::RSLP_HALT;
        end
      end
      rslp_pkg::RSLP_HALT: begin
        if (stop_req) begin
          st_d.from_halt = 1'b1;
          st_d.sga       = 1'b1;
          st_d.fsm       = rslp_pkg::RSLP_SGA_WAIT;
        end else if (wake) begin
          st_d.fsm = rslp_pkg::RSLP_NORMAL;
        end else if (snoop_seen) begin
          st_d.fsm = rslp_pkg::RSLP_HALT_SNP;
        end
      end
      rslp_pkg::RSLP_HALT_SNP: begin
        if (snoop_done) begin
          st_d.fsm = rslp_pkg::RSLP_HALT;
        end
      end
      rslp_pkg::RSLP_SGA_WAIT: begin
        if (sga_response) begin
          st_d.cnt = `RSLP_SG_CNT_W'(`RSLP_SG_ENTRY_CLKS - 1);
          st_d.fsm = rslp_pkg::RSLP_SG_DELAY;
        end
      end
      rslp_pkg::RSLP_SG_DELAY: begin
        if (st_q.cnt == `RSLP_SG_CNT_ZERO) begin
          st_d.fsm = rslp_pkg::RSLP_STOP;
        end else begin
          st_d.cnt = st_q.cnt - `RSLP_SG_CNT_ONE;
        end
      end
      rslp_pkg::RSLP_STOP: begin
        if (!stop_req) begin
          st_d.fsm = st_q.from_halt ? rslp_pkg::RSLP_HALT : rslp_pkg::RSLP_NORMAL;
        end else if (snoop_seen) begin
          st_d.fsm = rslp_pkg::RSLP_STOP_SNP;
        end
      end
      rslp_pkg::RSLP_STOP_SNP: begin
        if (snoop_done) begin
          st_d.fsm = rslp_pkg::RSLP_STOP;
        end
      end
      default: begin
        st_d.fsm = rslp_pkg::RSLP_NORMAL;
      end
    endcase
    // Release of clock stop from Normal-side stop grant returns to Normal.
    if (st_q.fsm == rslp_pkg::RSLP_STOP && !stop_req && !st_q.from_halt) begin
      st_d.fsm = rslp_pkg::RSLP_NORMAL;
    end
    // Initialization pulse follows the reset release.
    if (st_q.rst_seen) begin
      st_d.init     = 1'b1;
      st_d.rst_seen = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset in Stop Grant keeps the state while clock stop holds.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_q.fsm       <= (st_q.fsm == rslp_pkg::RSLP_STOP && stop_req) ?
                        rslp_pkg::RSLP_STOP : rslp_pkg::RSLP_NORMAL;
      st_q.cnt       <= `RSLP_SG_CNT_ZERO;
      st_q.from_halt <= 1'b0;
      st_q.sga       <= 1'b0;
      st_q.init      <= 1'b0;
      st_q.rst_seen  <= 1'b1;
      st_q.svc       <= `RSLP_EVT_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs.
  assign sga_issue          = st_q.sga;
  assign power_state        = st_q.fsm;
  assign in_stop_grant      = (st_q.fsm == rslp_pkg::RSLP_STOP);
  assign output_tristate    = strap_cfg[`RSLP_STRAP_TRISTATE];
  assign built_in_self_test = strap_cfg[`RSLP_STRAP_SELF_TEST];
  assign arb_id_sym         = strap_cfg[`RSLP_STRAP_ARB_ID];
  assign service_evt        = st_q.svc;
  assign init_pulse         = st_q.init;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_sga_resp;
    st_q.fsm == rslp_pkg::RSLP_SGA_WAIT && sga_response;
  endsequence

  a_sg_entry_delay: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_sga_resp ##1 (st_q.fsm == rslp_pkg::RSLP_SG_DELAY) [*8] |->
    ##12 (st_q.fsm == rslp_pkg::RSLP_SG_DELAY) ##1 (st_q.fsm == rslp_pkg::RSLP_STOP))
    else $error("Stop Grant entry delay is wrong.");

  a_sga_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(st_q.fsm == rslp_pkg::RSLP_SGA_WAIT)
    |-> sga_issue && ($past(st_q.fsm) inside {rslp_pkg::RSLP_NORMAL, rslp_pkg::RSLP_HALT}))
    else $error("Acknowledge cycle not issued.");

  a_halt_all: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(st_q.fsm) == rslp_pkg::RSLP_NORMAL && st_q.fsm == rslp_pkg::RSLP_HALT && !$past(smm_return)
    |-> $past(all_halted))
    else $error("Halt entered before all cores halted.");

  a_halt_wake: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_HALT && wake && !stop_req |=> st_q.fsm == rslp_pkg::RSLP_NORMAL)
    else $error("Halt did not wake on event.");

  a_stop_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm != rslp_pkg::RSLP_NORMAL |=> service_evt == `RSLP_EVT_NONE)
    else $error("Event serviced outside Normal.");

  a_stop_exit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_STOP && !stop_req
    |=> st_q.fsm == ($past(st_q.from_halt) ? rslp_pkg::RSLP_HALT : rslp_pkg::RSLP_NORMAL))
    else $error("Stop Grant exit went to the wrong state.");

  a_snoop_stay: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_STOP_SNP && !snoop_done |=> st_q.fsm == rslp_pkg::RSLP_STOP_SNP)
    else $error("Snoop state left before service.");

  a_snoop_back: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_HALT_SNP && snoop_done |=> st_q.fsm == rslp_pkg::RSLP_HALT)
    else $error("Halt snoop did not return to halt.");

  a_one_service: assert property (@(posedge ref_clk) disable iff (!rst_b)
    service_evt[`RSLP_EVT_INIT] && !$past(evt_in[`RSLP_EVT_INIT]) |=> !service_evt[`RSLP_EVT_INIT])
    else $error("Event serviced twice.");

  ////////////////////////////////////////////////////////////////////////////
  // A stop request is answered by the acknowledge cycle before any delay runs.
  a_stop_ack_issue: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_q.fsm == rslp_pkg::RSLP_HALT || (st_q.fsm == rslp_pkg::RSLP_NORMAL && !smm_return)) && stop_req
    |=> sga_issue && st_q.fsm == rslp_pkg::RSLP_SGA_WAIT)
    else $error("Clock stop request did not issue the acknowledge cycle.");

  // The block waits in the acknowledge state until the response phase arrives.
  a_ack_wait_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_SGA_WAIT && !sga_response
    |=> st_q.fsm == rslp_pkg::RSLP_SGA_WAIT && !sga_issue)
    else $error("Acknowledge wait left before the response phase.");

  // The entry source decides where a released clock stop goes back to.
  a_halt_stop_src: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_HALT && stop_req |=> st_q.from_halt)
    else $error("Clock stop from Halt was not marked.");

  a_norm_stop_src: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_NORMAL && stop_req && !smm_return |=> !st_q.from_halt)
    else $error("Clock stop from Normal was marked as Halt.");

  // Stop Grant holds while clock stop stands and no snoop arrives.
  a_stop_stays: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_STOP && stop_req && !snoop_seen
    |=> st_q.fsm == rslp_pkg::RSLP_STOP)
    else $error("Stop Grant left while clock stop holds.");

  // Snoops move to the snoop state that matches the current low power state.
  a_halt_snp_in: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_HALT && !stop_req && !wake && snoop_seen
    |=> st_q.fsm == rslp_pkg::RSLP_HALT_SNP)
    else $error("Snoop in Halt did not enter the Halt snoop state.");

  a_stop_snp_in: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_STOP && stop_req && snoop_seen
    |=> st_q.fsm == rslp_pkg::RSLP_STOP_SNP)
    else $error("Snoop in Stop Grant did not enter the Stop Grant snoop state.");

  // A handler return that selects Halt goes straight back to Halt.
  a_smm_to_halt: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_q.fsm == rslp_pkg::RSLP_NORMAL && smm_return && smm_return_to_halt
    |=> st_q.fsm == rslp_pkg::RSLP_HALT)
    else $error("Handler return did not resume in Halt.");

  ////////////////////////////////////////////////////////////////////////////
  // Reset steps; these carry no reset disable so that the reset cycles themselves are checked.
  sequence s_rst_release;
    !rst_b ##1 rst_b;
  endsequence

  a_init_release: assert property (@(posedge ref_clk)
    s_rst_release |=> init_pulse)
    else $error("No initialization pulse after reset release.");

  a_rst_keep_stop: assert property (@(posedge ref_clk)
    !rst_b && st_q.fsm == rslp_pkg::RSLP_STOP && stop_req
    |=> st_q.fsm == rslp_pkg::RSLP_STOP)
    else $error("Reset under clock stop left Stop Grant.");

  a_rst_normal: assert property (@(posedge ref_clk)
    !rst_b && !(st_q.fsm == rslp_pkg::RSLP_STOP && stop_req)
    |=> st_q.fsm == rslp_pkg::RSLP_NORMAL)
    else $error("Reset did not return to Normal.");

  ////////////////////////////////////////////////////////////////////////////
  // Per event type: a pending event is served from Normal, and once per occurrence.
  for (genvar g = 0; g < `RSLP_EVT_W; g++) begin : g_evt_chk
    a_evt_served: assert property (@(posedge ref_clk) disable iff (!rst_b)
      st_q.fsm == rslp_pkg::RSLP_NORMAL && evt_pend[g] |=> service_evt[g])
      else $error("Pending event not served in Normal.");

    a_evt_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
      service_evt[g] && !$past(evt_in[g]) |=> !service_evt[g])
      else $error("Event served twice for one occurrence.");
  end
endmodule

// ==== verification/rslp_chipset_model.sv ====
// Behavioural chipset model answering acknowledge cycles and snoops.
`timescale 1ns/1ps
module rslp_chipset_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       sga_issue,
  input  wire logic       snoop_seen,
  input  wire logic [3:0] resp_lat,
  output logic            sga_response,
  output logic            snoop_done
);
  logic [3:0] sga_wait_q;
  logic       sga_busy_q;
  logic [3:0] snp_wait_q;
  logic       snp_busy_q;
  //////////////////////////////////////////////////////////////////////////////
  // Ends the acknowledge cycle resp_lat + 1 clocks after it sees the issue; idle inputs stay inactive.
  always @(posedge ref_clk) begin
    sga_response <= 1'b0;
    if (!rst_b) begin
      sga_busy_q <= 1'b0;
    end else if (sga_issue === 1'b1) begin
      sga_busy_q <= 1'b1;
      sga_wait_q <= resp_lat;
    end else if (sga_busy_q && sga_wait_q == 4'h0) begin
      sga_response <= 1'b1;
      sga_busy_q   <= 1'b0;
    end else if (sga_busy_q) begin
      sga_wait_q <= sga_wait_q - 4'h1;
    end
  end
  // Services a snoop resp_lat + 1 clocks after it was seen.
  always @(posedge ref_clk) begin
    snoop_done <= 1'b0;
    if (!rst_b) begin
      snp_busy_q <= 1'b0;
    end else if (snoop_seen === 1'b1) begin
      snp_busy_q <= 1'b1;
      snp_wait_q <= resp_lat;
    end else if (snp_busy_q && snp_wait_q == 4'h0) begin
      snoop_done <= 1'b1;
      snp_busy_q <= 1'b0;
    end else if (snp_busy_q) begin
      snp_wait_q <= snp_wait_q - 4'h1;
    end
  end
endmodule

// ==== verification/rslp_seq_test.sv ====
// Self-checking bench for the reset strap and low power sequencer.
`timescale 1ns/1ps
`include "rslp_regs.svh"
module rslp_seq_test;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       sys_mgmt_irq_n = 1'b1;
  logic       self_test_strap_n = 1'b1;
  logic       bus_request_zero_n = 1'b1;
  logic       init_n = 1'b1;
  logic [1:0] local_irq_lines = 2'h0;
  logic       clock_stop_request_n = 1'b1;
  logic [1:0] core_halted = 2'h0;
  logic       smm_return = 1'b0;
  logic       smm_return_to_halt = 1'b0;
  logic       snoop_seen = 1'b0;
  logic [3:0] resp_lat = 4'h0;
  logic       snoop_done, sga_response, sga_issue, in_stop_grant, init_pulse;
  logic       output_tristate, built_in_self_test, arb_id_sym;
  logic [2:0] power_state;
  logic [3:0] service_evt;
  int         err_total = 0;
  int         check_count = 0;
  int         cyc_cnt = 0;
  int         svc_n [4];
  int         init_cnt, sga_cnt;
  //////////////////////////////////////////////////////////////////////////////
  // Device under test and the chipset on its far side.
  rslp_seq u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sys_mgmt_irq_n(sys_mgmt_irq_n),
    .self_test_strap_n(self_test_strap_n), .bus_request_zero_n(bus_request_zero_n), .init_n(init_n),
    .local_irq_lines(local_irq_lines), .clock_stop_request_n(clock_stop_request_n), .core_halted(core_halted),
    .smm_return(smm_return), .smm_return_to_halt(smm_return_to_halt), .snoop_seen(snoop_seen),
    .snoop_done(snoop_done), .sga_response(sga_response), .sga_issue(sga_issue), .power_state(power_state),
    .in_stop_grant(in_stop_grant), .output_tristate(output_tristate), .built_in_self_test(built_in_self_test),
    .arb_id_sym(arb_id_sym), .service_evt(service_evt), .init_pulse(init_pulse));
  rslp_chipset_model u_chipset (.ref_clk(ref_clk), .rst_b(rst_b), .sga_issue(sga_issue),
    .snoop_seen(snoop_seen), .resp_lat(resp_lat), .sga_response(sga_response), .snoop_done(snoop_done));
  // Clock at 25 MHz.
  always #20 ref_clk = ~ref_clk;
  // Counts output pulses and cuts a hung run short.
  always @(posedge ref_clk) begin
    cyc_cnt++;
    for (int i = 0; i < 4; i++) begin
      if (service_evt[i] === 1'b1) svc_n[i]++;
    end
    if (init_pulse === 1'b1) init_cnt++;
    if (sga_issue === 1'b1) sga_cnt++;
    if (cyc_cnt == 4000) begin
      err_total++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Compares one result and reports a mismatch.
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits n clocks and lets their updates land.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Waits a bounded time for a power state, then compares it.
  task automatic wait_st(input logic [2:0] s, input int lim);
    int i;
    i = 0;
    #1;
    while (power_state !== s && i < lim) begin
      cyc(1);
      i++;
    end
    chk({1'b0, power_state}, {1'b0, s});
  endtask
  // Clears the pulse counters.
  task automatic clr();
    svc_n = '{0, 0, 0, 0};
    init_cnt = 0;
    sga_cnt = 0;
  endtask
  // Drives one wake event: 0 mgmt, 1 init, 2 non-maskable, 3 maskable.
  task automatic evt(input int i, input logic on);
    if (i == 0) sys_mgmt_irq_n <= ~on;
    if (i == 1) init_n <= ~on;
    if (i == 2) local_irq_lines[1] <= on;
    if (i == 3) local_irq_lines[0] <= on;
  endtask
  // Resets for five clocks with the given straps asserted; no other address lines exist here.
  task automatic do_reset(input logic [2:0] m);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    {sys_mgmt_irq_n, self_test_strap_n, bus_request_zero_n} <= ~m;
    repeat (5) @(posedge ref_clk);
    clr();
    rst_b <= 1'b1;
    @(posedge ref_clk);
    {sys_mgmt_irq_n, self_test_strap_n, bus_request_zero_n} <= 3'h7;
    cyc(2);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Straps load at release, ignore later pin changes and reload on each reset.
  task automatic t_straps();
    do_reset(3'h5);
    chk({1'b0, output_tristate, built_in_self_test, arb_id_sym}, 4'h5);
    chk(init_cnt[3:0], 4'h1);
    @(posedge ref_clk);
    {sys_mgmt_irq_n, self_test_strap_n, bus_request_zero_n} <= 3'h0;
    cyc(2);
    {sys_mgmt_irq_n, self_test_strap_n, bus_request_zero_n} <= 3'h7;
    chk({1'b0, output_tristate, built_in_self_test, arb_id_sym}, 4'h5);
    do_reset(3'h2);
    chk({1'b0, output_tristate, built_in_self_test, arb_id_sym}, 4'h2);
  endtask
  // Halt needs both cores; each wake event returns to Normal and is served once.
  task automatic t_halt();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      core_halted <= 2'h1;
      cyc(4);
      chk({1'b0, power_state}, 4'h0);
      core_halted <= 2'h3;
      wait_st(rslp_pkg::RSLP_HALT, 6);
      clr();
      @(posedge ref_clk);
      evt(i, 1'b1);
      core_halted <= 2'h0;
      @(posedge ref_clk);
      evt(i, 1'b0);
      wait_st(rslp_pkg::RSLP_NORMAL, 5);
      cyc(3);
      chk(svc_n[i][3:0], 4'h1);
    end
  endtask
  // Stop grant from Normal with a slow chipset, events and a snoop inside it.
  task automatic t_stop();
    int i;
    i = 0;
    clr();
    @(posedge ref_clk);
    resp_lat <= 4'h3;
    clock_stop_request_n <= 1'b0;
    cyc(3);
    chk(sga_cnt[3:0], 4'h1);
    chk({1'b0, power_state}, 4'h3);
    @(posedge ref_clk);
    while (sga_response !== 1'b1 && i < 20) begin
      @(posedge ref_clk);
      i++;
    end
    repeat (19) @(posedge ref_clk);
    #1;
    chk({1'b0, power_state}, 4'h4);
    cyc(1);
    chk({3'h0, in_stop_grant}, 4'h1);
    for (i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      evt(1, 1'b1);
      evt(2, 1'b1);
      @(posedge ref_clk);
      evt(1, 1'b0);
      evt(2, 1'b0);
    end
    cyc(3);
    chk(4'(svc_n[1] + svc_n[2]), 4'h0);
    snoop_seen <= 1'b1;
    @(posedge ref_clk);
    snoop_seen <= 1'b0;
    wait_st(rslp_pkg::RSLP_STOP_SNP, 2);
    wait_st(rslp_pkg::RSLP_STOP, 10);
    @(posedge ref_clk);
    clock_stop_request_n <= 1'b1;
    wait_st(rslp_pkg::RSLP_NORMAL, 5);
    cyc(6);
    chk({svc_n[2][1:0], svc_n[1][1:0]}, 4'h5);
  endtask
  // Snoop and stop grant from Halt, then a reset in Halt.
  task automatic t_halt_stop();
    @(posedge ref_clk);
    resp_lat <= 4'h0;
    core_halted <= 2'h3;
    wait_st(rslp_pkg::RSLP_HALT, 6);
    snoop_seen <= 1'b1;
    @(posedge ref_clk);
    snoop_seen <= 1'b0;
    wait_st(rslp_pkg::RSLP_HALT_SNP, 2);
    wait_st(rslp_pkg::RSLP_HALT, 8);
    clock_stop_request_n <= 1'b0;
    wait_st(rslp_pkg::RSLP_STOP, 40);
    clock_stop_request_n <= 1'b1;
    wait_st(rslp_pkg::RSLP_HALT, 5);
    core_halted <= 2'h0;
    do_reset(3'h0);
    chk({init_cnt[1:0], 1'b0, power_state[0]}, 4'h4);
  endtask
  // Handler return resumes in Normal or Halt as selected.
  task automatic t_smm();
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      smm_return <= 1'b1;
      smm_return_to_halt <= i[0];
      @(posedge ref_clk);
      smm_return <= 1'b0;
      wait_st(i[0] ? rslp_pkg::RSLP_HALT : rslp_pkg::RSLP_NORMAL, 4);
    end
    evt(1, 1'b1);
    @(posedge ref_clk);
    evt(1, 1'b0);
    wait_st(rslp_pkg::RSLP_NORMAL, 5);
  endtask
  // Reset in stop grant initializes but holds the state until the request drops.
  task automatic t_reset_sg();
    clock_stop_request_n <= 1'b0;
    wait_st(rslp_pkg::RSLP_STOP, 40);
    do_reset(3'h0);
    chk({init_cnt[0], power_state}, 4'hD);
    clock_stop_request_n <= 1'b1;
    wait_st(rslp_pkg::RSLP_NORMAL, 5);
  endtask
  // Main sequence.
  initial begin
    do_reset(3'h0);
    t_straps();
    t_halt();
    t_stop();
    t_halt_stop();
    t_smm();
    t_reset_sg();
    test_done();
  end
endmodule
